/* File: include/pml_cfg.svh */
`ifndef PML_CFG_SVH
`define PML_CFG_SVH

// management register addresses
`define PML_CTRL_ADDR 5'h00
`define PML_LATCH_ADDR 5'h1e

// control register field positions
`define PML_B_RESET 15
`define PML_B_LOOP 14
`define PML_B_RATE 13
`define PML_B_AN_EN 12
`define PML_B_LOW_PWR 11
`define PML_B_ISOLATE 10
`define PML_B_AN_RESTART 9
`define PML_B_DUPLEX 8
`define PML_B_COL_TEST 7

// control register defaults (isolate comes from the address strap)
`define PML_RST_LOOP 1'b0
`define PML_RST_RATE 1'b1
`define PML_RST_AN_EN 1'b1
`define PML_RST_LOW_PWR 1'b0
`define PML_RST_DUPLEX 1'b0
`define PML_RST_COL_TEST 1'b0

// serial frame layout
`define PML_PRE_BITS 6'd32
`define PML_HDR_BITS 6'd14
`define PML_DATA_LAST 6'd15
`define PML_ST_CODE 2'b01
`define PML_OP_READ 2'b10
`define PML_OP_WRITE 2'b01

// timing
`define PML_CLK_MHZ 100
`define PML_SW_RST_NS 2000
`define PML_SW_RST_CYC ((`PML_SW_RST_NS * `PML_CLK_MHZ + 999) / 1000)

`endif

/* File: include/pml_pkg.sv */
package pml_pkg;
	// serial frame receiver states
	typedef enum logic [3:0] {
		PML_FS_PRE = 4'h1,
		PML_FS_HDR = 4'h2,
		PML_FS_TA = 4'h4,
		PML_FS_DATA = 4'h8
	} pml_frame_st_t;
endpackage

/* File: verilog/pml_mdio_frame.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pml_cfg.svh"
module pml_mdio_frame
	import pml_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_i,
	input wire logic [4:0] phy_addr,
	input wire logic busy,
	input wire logic [15:0] rdata,
	output logic mdio_o,
	output logic mdio_oe_n,
	output logic rd_pulse,
	output logic wr_pulse,
	output logic [4:0] reg_addr,
	output logic [15:0] wdata
);
	logic [1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
	pml_frame_st_t st_q, st_d;
	logic [5:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d, wdata_d;
	logic rd_op_q, rd_op_d, o_d, oe_n_d, rdp_d, wrp_d, rise, bit_in;
	logic [4:0] addr_d;

	// pin level follows only once stages two and three agree
	always_comb
	begin
		lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		rise = lvl_d[1] & ~lvl_q[1];
		bit_in = lvl_d[0];
	end

	// frame walk: preamble, header, turnaround, data
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rd_op_d = rd_op_q;
		o_d = mdio_o;
		oe_n_d = mdio_oe_n;
		rdp_d = 1'b0;
		wrp_d = 1'b0;
		addr_d = reg_addr;
		wdata_d = wdata;
		if (busy)
		begin
			st_d = PML_FS_PRE;
			cnt_d = 6'h0;
			oe_n_d = 1'b1;
		end
		else if (rise)
		begin
			unique case (st_q)
				PML_FS_PRE:
				begin
					if (bit_in)
						cnt_d = (cnt_q == `PML_PRE_BITS) ? cnt_q : cnt_q + 6'h1;
					else if (cnt_q == `PML_PRE_BITS)
					begin
						st_d = PML_FS_HDR;
						cnt_d = 6'h1;
						sh_d = 16'h0;
					end
					else
						cnt_d = 6'h0;
				end
				PML_FS_HDR:
				begin
					sh_d = {sh_q[14:0], bit_in};
					cnt_d = cnt_q + 6'h1;
					if (cnt_q == `PML_HDR_BITS - 6'h1)
					begin
						cnt_d = 6'h0;
						if (sh_d[13:12] == `PML_ST_CODE && sh_d[9:5] == phy_addr &&
							(sh_d[11:10] == `PML_OP_READ || sh_d[11:10] == `PML_OP_WRITE))
						begin
							st_d = PML_FS_TA;
							rd_op_d = (sh_d[11:10] == `PML_OP_READ);
							addr_d = sh_d[4:0];
							rdp_d = rd_op_d;
						end
						else
							st_d = PML_FS_PRE;
					end
				end
				PML_FS_TA:
				begin
					cnt_d = cnt_q + 6'h1;
					if (cnt_q == 6'h0 && rd_op_q)
					begin
						oe_n_d = 1'b0;
						o_d = 1'b0;
					end
					else if (cnt_q != 6'h0)
					begin
						st_d = PML_FS_DATA;
						cnt_d = 6'h0;
						if (rd_op_q)
						begin
							o_d = rdata[15];
							sh_d = {rdata[14:0], 1'b0};
						end
					end
				end
				PML_FS_DATA:
				begin
					cnt_d = cnt_q + 6'h1;
					if (rd_op_q)
					begin
						o_d = sh_q[15];
						sh_d = {sh_q[14:0], 1'b0};
					end
					else
						sh_d = {sh_q[14:0], bit_in};
					if (cnt_q == `PML_DATA_LAST)
					begin
						st_d = PML_FS_PRE;
						cnt_d = 6'h0;
						oe_n_d = 1'b1;
						wrp_d = ~rd_op_q;
						wdata_d = sh_d;
					end
				end
			endcase
		end
	end

	// registers of the frame receiver
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			lvl_q <= 2'h0;
			st_q <= PML_FS_PRE;
			cnt_q <= 6'h0;
			sh_q <= 16'h0;
			rd_op_q <= 1'b0;
			mdio_o <= 1'b0;
			mdio_oe_n <= 1'b1;
			rd_pulse <= 1'b0;
			wr_pulse <= 1'b0;
			reg_addr <= 5'h0;
			wdata <= 16'h0;
		end
		else
		begin
			s1_q <= {mdc, mdio_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rd_op_q <= rd_op_d;
			mdio_o <= o_d;
			mdio_oe_n <= oe_n_d;
			rd_pulse <= rdp_d;
			wr_pulse <= wrp_d;
			reg_addr <= addr_d;
			wdata <= wdata_d;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/pml_mgmt_regs.sv */
// Functional notes
// - latch-high bit holds one until read
// - read reloads latch-high with live level
// - latch-low bit holds zero until read
// - read reloads latch-low with live level
// - max group updates only on larger value
// - max group holds; read reloads current state
// - self-clear bits start function, clear when done
// - 16-bit control register at address zero
// - bit 15 soft reset, self-clears when done
// - accesses ignored during soft reset
// - loopback disables line, collision unless test
// - loopback returns transmit data to receive
// - rate, autoneg, power, restart, duplex fields
// - isolate default one when address zero
// - rate from bit 13 unless autoneg on or hardware mode
// - restart ignored while autoneg disabled
// - isolate floats and ignores MAC side
// - collision test drives collision from transmit enable
`timescale 1ns/1ps
`default_nettype none
`include "pml_cfg.svh"
module pml_mgmt_regs
	import pml_pkg::*;
#(
	parameter int HI_W = 4,
	parameter int LO_W = 4,
	parameter int MX_W = 3
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	input wire logic config_source_pin,
	input wire logic hw_speed_sel,
	input wire logic hw_an_sel,
	input wire logic hw_duplex_sel,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic an_started,
	input wire logic [HI_W-1:0] hi_event,
	input wire logic [LO_W-1:0] lo_event_n,
	input wire logic [MX_W-1:0] sm_state,
	input wire logic mac_txen,
	input wire logic [3:0] mac_txd,
	output logic mac_rxdv,
	output logic [3:0] mac_rxd,
	output logic mac_col,
	output logic mac_oe_n,
	output logic speed_100,
	output logic full_duplex,
	output logic an_enable,
	output logic an_restart,
	output logic low_power,
	output logic loopback,
	output logic line_tx_en,
	output logic line_rx_en,
	output logic col_det_en,
	output logic soft_reset_busy
);
	localparam logic [15:0] RstCyc = 16'(`PML_SW_RST_CYC);

	// access strobe for one register
	function automatic logic hit(input logic strobe, input logic [4:0] a, input logic [4:0] t);
		hit = strobe && (a == t);
	endfunction

	// larger of stored and present group value
	function automatic logic [MX_W-1:0] max_of(input logic [MX_W-1:0] s, input logic [MX_W-1:0] c);
		max_of = (c > s) ? c : s;
	endfunction

	logic rd_pulse, wr_pulse;
	logic [4:0] acc_addr;
	logic [15:0] wdata, rdata_q, rdata_d;
	logic [13:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_d;
	logic [2:0] strap_cnt_q, strap_cnt_d;
	logic [4:0] addr_q, addr_d;
	logic loop_q, rate_q, an_en_q, lp_q, iso_q, restart_q, duplex_q, coltest_q;
	logic loop_d, rate_d, an_en_d, lp_d, iso_d, restart_d, duplex_d, coltest_d;
	logic busy_q, busy_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic [HI_W-1:0] hi_q, hi_d;
	logic [LO_W-1:0] lo_q, lo_d;
	logic [MX_W-1:0] mx_q, mx_d;
	logic rxdv_d, col_d, oe_n_d, spd_d, dpx_d, ane_d, ltx_d, lrx_d, cde_d;
	logic [3:0] rxd_d;
	logic sw_mode, txen_s;
	logic [3:0] txd_s;

	// serial management frames, silent while soft reset runs
	pml_mdio_frame u_frame (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.mdc(mdc),
		.mdio_i(mdio_i),
		.phy_addr(addr_q),
		.busy(busy_q),
		.rdata(rdata_q),
		.mdio_o(mdio_o),
		.mdio_oe_n(mdio_oe_n),
		.rd_pulse(rd_pulse),
		.wr_pulse(wr_pulse),
		.reg_addr(acc_addr),
		.wdata(wdata)
	);

	// pin levels move once stages two and three agree
	always_comb
	begin
		pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
		strap_cnt_d = (strap_cnt_q == 3'h4) ? strap_cnt_q : strap_cnt_q + 3'h1;
		// strap taken only once it has passed all three stages
		addr_d = (strap_cnt_q == 3'h3) ? pin_s3_q[4:0] : addr_q;
		sw_mode = pin_q[13];
		txen_s = pin_q[9];
		txd_s = pin_q[8:5];
	end

	// control register next state
	always_comb
	begin
		loop_d = loop_q;
		rate_d = rate_q;
		an_en_d = an_en_q;
		lp_d = lp_q;
		iso_d = iso_q;
		restart_d = restart_q;
		duplex_d = duplex_q;
		coltest_d = coltest_q;
		busy_d = busy_q;
		rcnt_d = rcnt_q;
		if (strap_cnt_q == 3'h3)
			iso_d = (pin_s3_q[4:0] == 5'h0);
		if (busy_q)
		begin
			loop_d = `PML_RST_LOOP;
			rate_d = `PML_RST_RATE;
			an_en_d = `PML_RST_AN_EN;
			lp_d = `PML_RST_LOW_PWR;
			iso_d = (addr_q == 5'h0);
			restart_d = 1'b0;
			duplex_d = `PML_RST_DUPLEX;
			coltest_d = `PML_RST_COL_TEST;
			rcnt_d = rcnt_q - 16'h1;
			if (rcnt_q == 16'h1)
				busy_d = 1'b0;
		end
		else
		begin
			if (an_started)
				restart_d = 1'b0;
			if (hit(wr_pulse, acc_addr, `PML_CTRL_ADDR))
			begin
				if (wdata[`PML_B_RESET])
				begin
					busy_d = 1'b1;
					rcnt_d = RstCyc;
				end
				else
				begin
					loop_d = wdata[`PML_B_LOOP];
					rate_d = wdata[`PML_B_RATE];
					an_en_d = wdata[`PML_B_AN_EN];
					lp_d = wdata[`PML_B_LOW_PWR];
					iso_d = wdata[`PML_B_ISOLATE];
					duplex_d = wdata[`PML_B_DUPLEX];
					coltest_d = wdata[`PML_B_COL_TEST];
					if (wdata[`PML_B_AN_RESTART] && wdata[`PML_B_AN_EN])
						restart_d = 1'b1;
				end
			end
		end
	end

	// latching status bits and read data
	always_comb
	begin
		hi_d = hi_q | hi_event;
		lo_d = lo_q & lo_event_n;
		mx_d = max_of(mx_q, sm_state);
		rdata_d = rdata_q;
		if (hit(rd_pulse, acc_addr, `PML_LATCH_ADDR))
		begin
			hi_d = hi_event;
			lo_d = lo_event_n;
			mx_d = sm_state;
			rdata_d = 16'({mx_q, lo_q, hi_q});
		end
		else if (hit(rd_pulse, acc_addr, `PML_CTRL_ADDR))
			rdata_d = {busy_q, loop_q, rate_q, an_en_q, lp_q, iso_q, restart_q,
				duplex_q, coltest_q, 7'h0};
		else if (rd_pulse)
			rdata_d = 16'h0;
		if (busy_q || (lp_d && !lp_q))
		begin
			hi_d = '0;
			lo_d = '1;
			mx_d = '0;
		end
	end

	// MAC side, line enables and resolved modes
	always_comb
	begin
		rxdv_d = loop_q && !iso_q && !lp_q && txen_s;
		rxd_d = rxdv_d ? txd_s : 4'h0;
		col_d = coltest_q && !iso_q && !lp_q && txen_s;
		oe_n_d = iso_q;
		spd_d = !sw_mode ? pin_q[12] : (an_en_q ? an_speed_100 : rate_q);
		dpx_d = !sw_mode ? pin_q[10] : (an_en_q ? an_full_duplex : duplex_q);
		ane_d = sw_mode ? an_en_q : pin_q[11];
		ltx_d = !loop_q && !lp_q;
		lrx_d = !loop_q && !lp_q;
		cde_d = !loop_q || coltest_q;
	end

	// all registers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_q <= 14'h0;
			pin_s2_q <= 14'h0;
			pin_s3_q <= 14'h0;
			pin_q <= 14'h0;
			strap_cnt_q <= 3'h0;
			addr_q <= 5'h0;
			loop_q <= `PML_RST_LOOP;
			rate_q <= `PML_RST_RATE;
			an_en_q <= `PML_RST_AN_EN;
			lp_q <= `PML_RST_LOW_PWR;
			iso_q <= 1'b1;
			restart_q <= 1'b0;
			duplex_q <= `PML_RST_DUPLEX;
			coltest_q <= `PML_RST_COL_TEST;
			busy_q <= 1'b0;
			rcnt_q <= 16'h0;
			hi_q <= '0;
			lo_q <= '1;
			mx_q <= '0;
			rdata_q <= 16'h0;
			mac_rxdv <= 1'b0;
			mac_rxd <= 4'h0;
			mac_col <= 1'b0;
			mac_oe_n <= 1'b1;
			speed_100 <= 1'b0;
			full_duplex <= 1'b0;
			an_enable <= 1'b0;
			line_tx_en <= 1'b0;
			line_rx_en <= 1'b0;
			col_det_en <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {config_source_pin, hw_speed_sel, hw_an_sel, hw_duplex_sel,
				mac_txen, mac_txd, phy_addr};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= pin_d;
			strap_cnt_q <= strap_cnt_d;
			addr_q <= addr_d;
			loop_q <= loop_d;
			rate_q <= rate_d;
			an_en_q <= an_en_d;
			lp_q <= lp_d;
			iso_q <= iso_d;
			restart_q <= restart_d;
			duplex_q <= duplex_d;
			coltest_q <= coltest_d;
			busy_q <= busy_d;
			rcnt_q <= rcnt_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			mx_q <= mx_d;
			rdata_q <= rdata_d;
			mac_rxdv <= rxdv_d;
			mac_rxd <= rxd_d;
			mac_col <= col_d;
			mac_oe_n <= oe_n_d;
			speed_100 <= spd_d;
			full_duplex <= dpx_d;
			an_enable <= ane_d;
			line_tx_en <= ltx_d;
			line_rx_en <= lrx_d;
			col_det_en <= cde_d;
		end
	end

	assign an_restart = restart_q;
	assign low_power = lp_q;
	assign loopback = loop_q;
	assign soft_reset_busy = busy_q;
endmodule
`default_nettype wire

/* File: verification/pml_mgmt_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pml_mgmt_regs_chk
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdio_oe_n,
	input wire logic config_source_pin,
	input wire logic an_started,
	input wire logic mac_txen,
	input wire logic mac_rxdv,
	input wire logic mac_col,
	input wire logic mac_oe_n,
	input wire logic speed_100,
	input wire logic an_enable,
	input wire logic an_restart,
	input wire logic low_power,
	input wire logic loopback,
	input wire logic line_tx_en,
	input wire logic line_rx_en,
	input wire logic col_det_en,
	input wire logic soft_reset_busy
);
	logic [8:0] busy_cnt_q;
	logic [8:0] busy_cnt_d;
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// length of the soft reset window
	always_comb
	begin
		busy_cnt_d = soft_reset_busy ? busy_cnt_q + 9'h001 : 9'h000;
	end
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			busy_cnt_q <= 9'h000;
		else
			busy_cnt_q <= busy_cnt_d;
	end
	property p_busy_len;
		$fell(soft_reset_busy) |-> busy_cnt_q inside {[199:201]};
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("soft reset length");
	property p_busy_quiet;
		soft_reset_busy |-> mdio_oe_n;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("drive in reset");
	property p_srst_dflt;
		$fell(soft_reset_busy) |-> !loopback && !low_power && !an_restart;
	endproperty
	a_srst_dflt: assert property (p_srst_dflt) else $error("not default");
	property p_loop_line;
		$rose(loopback) |-> ##[1:2] (!line_tx_en && !line_rx_en);
	endproperty
	a_loop_line: assert property (p_loop_line) else $error("line on in loop");
	property p_rxdv;
		loopback && !mac_oe_n && $rose(mac_txen) |-> ##[1:512] mac_rxdv;
	endproperty
	a_rxdv: assert property (p_rxdv) else $error("rxdv late");
	property p_col_on;
		loopback && col_det_en && !mac_oe_n && $rose(mac_txen) |-> ##[1:512] mac_col;
	endproperty
	a_col_on: assert property (p_col_on) else $error("col late");
	property p_col_off;
		loopback && col_det_en && !speed_100 && $fell(mac_txen) |-> ##[1:40] !mac_col;
	endproperty
	a_col_off: assert property (p_col_off) else $error("col stuck");
	property p_restart_clr;
		an_restart && an_started |-> ##[1:2] !an_restart;
	endproperty
	a_restart_clr: assert property (p_restart_clr) else $error("restart kept");
	property p_restart_en;
		$rose(an_restart) && config_source_pin |-> ##[0:2] an_enable;
	endproperty
	a_restart_en: assert property (p_restart_en) else $error("restart w/o an");
	property p_iso;
		mac_oe_n |-> !mac_rxdv && !mac_col;
	endproperty
	a_iso: assert property (p_iso) else $error("isolated output active");
	c_srst: cover property ($fell(soft_reset_busy));
	c_col: cover property (loopback && mac_col);
	c_restart: cover property (an_restart && an_started);
endmodule
bind pml_mgmt_regs pml_mgmt_regs_chk u_chk (.sys_clk, .nrst, .mdio_oe_n, .config_source_pin,
	.an_started, .mac_txen, .mac_rxdv, .mac_col, .mac_oe_n, .speed_100, .an_enable, .an_restart,
	.low_power, .loopback, .line_tx_en, .line_rx_en, .col_det_en, .soft_reset_busy);
`default_nettype wire

/* File: verification/pml_sta_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pml_sta_model
(
	output logic mdc,
	output logic mdio_i,
	input wire logic mdio_o,
	input wire logic mdio_oe_n,
	input wire logic [4:0] phy
);
	logic drv;
	logic drv_bit;
	// wire level: device, station, else pull-up
	assign mdio_i = !mdio_oe_n ? mdio_o : (drv ? drv_bit : 1'b1);
	initial
	begin
		mdc = 1'b0;
		drv = 1'b0;
		drv_bit = 1'b1;
	end
	// one frame; mdc runs only inside it, 80 ns period
	task automatic xfer(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hffffffff, 2'b01, wr ? 2'b01 : 2'b10, phy, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--)
		begin
			drv = wr || i >= 18;
			drv_bit = f[i];
			#40;
			mdc = 1'b1;
			rd = {rd[14:0], mdio_i};
			#40;
			mdc = 1'b0;
		end
		drv = 1'b0;
		#100;
	endtask
endmodule
`default_nettype wire

/* File: verification/pml_mgmt_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pml_cfg.svh"
module pml_mgmt_regs_tb;
	logic sys_clk, nrst, mdc, mdio_i, mdio_o, mdio_oe_n, an_speed_100, an_started;
	logic [4:0] phy_addr;
	logic [3:0] hi_event, lo_event_n, mac_txd, mac_rxd;
	logic cfg_sw, hw_spd;
	logic [2:0] sm_state;
	logic mac_txen, mac_rxdv, mac_col, mac_oe_n, speed_100, full_duplex, an_enable;
	logic an_restart, low_power, loopback, line_tx_en, line_rx_en, col_det_en, soft_reset_busy;
	int n_errors, cmp_count;
	pml_mgmt_regs u_dut (.sys_clk, .nrst, .mdc, .mdio_i, .mdio_o, .mdio_oe_n, .phy_addr,
		.config_source_pin(cfg_sw), .hw_speed_sel(hw_spd), .hw_an_sel(1'b0), .hw_duplex_sel(1'b0),
		.an_speed_100, .an_full_duplex(1'b0), .an_started, .hi_event, .lo_event_n, .sm_state,
		.mac_txen, .mac_txd, .mac_rxdv, .mac_rxd, .mac_col, .mac_oe_n, .speed_100, .full_duplex,
		.an_enable, .an_restart, .low_power, .loopback, .line_tx_en, .line_rx_en, .col_det_en,
		.soft_reset_busy);
	pml_sta_model u_sta (.mdc, .mdio_i, .mdio_o, .mdio_oe_n, .phy(phy_addr));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
		logic [15:0] v;
		u_sta.xfer(1'b0, a, 16'h0000, v);
		chk(nm, v, e);
	endtask
	task automatic wr(input logic [15:0] d);
		logic [15:0] v;
		u_sta.xfer(1'b1, `PML_CTRL_ADDR, d, v);
		tick(1);
	endtask
	task automatic do_rst(input logic [4:0] a);
		nrst = 1'b0;
		phy_addr = a;
		tick(12);
		nrst = 1'b1;
		tick(10);
	endtask
	// hang guard, well above the expected run
	initial
	begin
		#400000;
		n_errors++;
		end_sim();
	end
	initial
	begin
		{an_speed_100, an_started, mac_txen, mac_txd, sm_state, hi_event} = '0;
		lo_event_n = 4'hf;
		cfg_sw = 1'b1;
		hw_spd = 1'b0;
		do_rst(5'h00);
		rd(`PML_CTRL_ADDR, 16'h3400, "ctrl_iso");
		chk("mac_oe_n", mac_oe_n, 1'b1);
		do_rst(5'h03);
		rd(`PML_CTRL_ADDR, 16'h3000, "ctrl_dflt");
		rd(5'h01, 16'h0000, "unmapped");
		// short events, then quiet live levels
		hi_event = 4'h5;
		lo_event_n = 4'h6;
		sm_state = 3'd6;
		tick(2);
		hi_event = 4'h0;
		lo_event_n = 4'hf;
		sm_state = 3'd2;
		tick(2);
		rd(`PML_LATCH_ADDR, 16'h0665, "latch_hist");
		rd(`PML_LATCH_ADDR, 16'h02f0, "latch_live");
		wr(16'h2100);
		rd(`PML_CTRL_ADDR, 16'h2100, "ctrl_wr");
		chk("modes100", {speed_100, full_duplex, an_enable}, 3'b110);
		wr(16'h0300);
		rd(`PML_CTRL_ADDR, 16'h0100, "restart_off");
		chk("modes10", {speed_100, full_duplex, an_enable}, 3'b010);
		// hardware mode: rate and duplex come from the select pins
		cfg_sw = 1'b0;
		hw_spd = 1'b1;
		tick(8);
		chk("hw_modes", {speed_100, full_duplex, an_enable}, 3'b100);
		cfg_sw = 1'b1;
		hw_spd = 1'b0;
		tick(8);
		wr(16'h3200);
		chk("restart", {an_restart, speed_100}, 2'b10);
		an_started = 1'b1;
		tick(1);
		an_started = 1'b0;
		tick(3);
		rd(`PML_CTRL_ADDR, 16'h3000, "restart_clr");
		wr(16'h4080);
		chk("loop", {loopback, line_tx_en, line_rx_en, col_det_en}, 4'b1001);
		mac_txd = 4'ha;
		mac_txen = 1'b1;
		tick(20);
		chk("loop_rx", {mac_rxdv, mac_rxd, mac_col}, 6'b110101);
		mac_txen = 1'b0;
		tick(40);
		chk("col_off", mac_col, 1'b0);
		wr(16'h4000);
		chk("loop_nocol", col_det_en, 1'b0);
		wr(16'h0800);
		chk("low_pwr", {low_power, line_tx_en, mac_rxdv}, 3'b100);
		wr(16'h8000);
		chk("busy", soft_reset_busy, 1'b1);
		rd(`PML_CTRL_ADDR, 16'hffff, "ignored");
		rd(`PML_CTRL_ADDR, 16'h3000, "after_srst");
		end_sim();
	end
endmodule
`default_nettype wire
